/* pkg/lcd_pkg.sv */
// Shared constants and types of the LCD driver command decoder.
package lcd_pkg;
  // Command bytes.
  localparam logic [7:0] CMD_DISPLAY_DATA = 8'h80;
  localparam logic [7:0] CMD_MODE_SET = 8'h82;
  localparam logic [7:0] CMD_SYSTEM_SET = 8'h84;
  localparam logic [7:0] CMD_FRAME_FREQ = 8'h86;
  localparam logic [7:0] CMD_BLINK = 8'h88;
  localparam logic [7:0] CMD_VOLTAGE_SET = 8'h8A;
  // Field positions in the setting bytes.
  localparam int ADDR_MSB = 5;
  localparam int DUTY_BIT = 1;
  localparam int BIAS_BIT = 0;
  localparam int SYS_OSC_BIT = 1;
  localparam int SYS_DISP_BIT = 0;
  localparam int FRAME_BIT = 0;
  localparam int BLINK_HI_BIT = 1;
  localparam int BLINK_LO_BIT = 0;
  localparam int VSEL_BIT = 5;
  localparam int VADJ_BIT = 4;
  localparam int VLVL_MSB = 3;
  // Reset values.
  localparam logic [5:0] ADDR_RST = 6'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] SYS_RST = 2'h0;
  localparam logic FRAME_RST = 1'h0;
  localparam logic [1:0] BLINK_RST = 2'h0;
  localparam logic [7:0] VOLT_RST = 8'h30;
  // Display RAM shape.
  localparam int RAM_DEPTH = 16;
  localparam int RAM_AW = 4;
  // Kind of byte event passed from the link.
  typedef enum logic [1:0] {LCD_EV_CMD, LCD_EV_WR, LCD_EV_RD} lcd_ev_e;
endpackage : lcd_pkg

/* pkg/lcd_byte_if.sv */
// Byte event handshake between the link domain and the core domain.
`timescale 1ns/1ps
`default_nettype none
interface lcd_byte_if;
  logic req_tgl;
  logic ack_tgl;
  lcd_pkg::lcd_ev_e kind;
  logic [7:0] data;
  logic [7:0] rd_data;
  modport link (output req_tgl, output kind, output data, input ack_tgl, input rd_data);
  modport core (input req_tgl, input kind, input data, output ack_tgl, output rd_data);
endinterface : lcd_byte_if
`default_nettype wire

/* verilog/lcd_link_rx.sv */
// Link-domain byte capture with a toggle handshake into the core domain.
`timescale 1ns/1ps
`default_nettype none
module lcd_link_rx (
  // Link clock and core reset.
  input wire logic lk_clk,
  input wire logic rst_n,
  // Byte stream from the serial front end.
  input wire logic lk_byte_valid,
  input wire logic lk_byte_first,
  input wire logic [7:0] lk_byte,
  input wire logic lk_read_req,
  output logic lk_busy,
  output logic lk_rd_valid,
  output logic [7:0] lk_rd_data,
  // Crossing to the core.
  lcd_byte_if.link bi
);
  logic rst_meta_ff, rst_ff;
  logic ack_meta_ff, ack_ff, ack_prev_ff;
  logic req_ff, rd_wait_ff, rd_valid_ff;
  logic [7:0] data_ff, rd_data_ff;
  lcd_pkg::lcd_ev_e kind_ff;
  logic issue;

  // Reset reaches the link domain through two flops.
  always_ff @(posedge lk_clk) begin
    rst_meta_ff <= rst_n;
    rst_ff <= rst_meta_ff;
  end

  always_ff @(posedge lk_clk) begin
    if (!rst_ff) begin
      ack_meta_ff <= 1'b0;
      ack_ff <= 1'b0;
      ack_prev_ff <= 1'b0;
    end else begin
      ack_meta_ff <= bi.ack_tgl;
      ack_ff <= ack_meta_ff;
      ack_prev_ff <= ack_ff;
    end
  end

  // A byte offered while busy is not taken; the source must hold it.
  assign lk_busy = (req_ff != ack_ff);
  assign issue = !lk_busy && (lk_byte_valid || lk_read_req);

  always_ff @(posedge lk_clk) begin
    if (!rst_ff) begin
      req_ff <= 1'b0;
      data_ff <= 8'h00;
      kind_ff <= lcd_pkg::LCD_EV_CMD;
      rd_wait_ff <= 1'b0;
    end else if (issue) begin
      req_ff <= !req_ff;
      data_ff <= lk_byte;
      rd_wait_ff <= !lk_byte_valid;
      if (!lk_byte_valid) kind_ff <= lcd_pkg::LCD_EV_RD;
      else if (lk_byte_first) kind_ff <= lcd_pkg::LCD_EV_CMD;
      else kind_ff <= lcd_pkg::LCD_EV_WR;
    end
  end

  // Read data is loaded by the core on the same edge as its ack toggle and then held.
  always_ff @(posedge lk_clk) begin
    if (!rst_ff) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      rd_valid_ff <= rd_wait_ff && (ack_ff != ack_prev_ff);
      if (rd_wait_ff && (ack_ff != ack_prev_ff)) rd_data_ff <= bi.rd_data;
    end
  end

  assign bi.req_tgl = req_ff;
  assign bi.kind = kind_ff;
  assign bi.data = data_ff;
  assign lk_rd_valid = rd_valid_ff;
  assign lk_rd_data = rd_data_ff;
endmodule : lcd_link_rx
`default_nettype wire

/* verilog/lcd_display_ram.sv */
// Display RAM with one write port and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module lcd_display_ram (
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic we,
  input wire logic [lcd_pkg::RAM_AW-1:0] wa,
  input wire logic [7:0] wd,
  // Read ports.
  input wire logic [lcd_pkg::RAM_AW-1:0] ra,
  output logic [7:0] rq,
  input wire logic [lcd_pkg::RAM_AW-1:0] da,
  output logic [7:0] dq
);
  logic [7:0] mem [lcd_pkg::RAM_DEPTH];
  logic [7:0] rq_ff, dq_ff;

  // Contents are undefined until written, as on any static RAM.
  always_ff @(posedge clk) begin
    if (we) mem[wa] <= wd;
  end

  always_ff @(posedge clk) begin
    rq_ff <= mem[ra];
    dq_ff <= mem[da];
  end

  assign rq = rq_ff;
  assign dq = dq_ff;
endmodule : lcd_display_ram
`default_nettype wire

/* verilog/lcd_cmd_decoder.sv */
// Command decoder of the segment LCD driver: settings, RAM pointer and RAM.
// How it works
// - display-data command loads six-bit start address
// - pointer advances after every data write or read
// - data bytes stored in display RAM
// - mode-set byte picks duty and bias
// - system-set byte switches oscillator and display
// - frame byte picks normal or doubled rate
// - blink byte picks off, 2, 1, 0.5 Hz
// - voltage-set byte loads pin, enable, level
// - pin-select bit chooses supply pin or segment
// - adjust enable follows its bit
// - zero level code disables voltage follower
// - segment pin without adjustment keeps follower off
// - segment pin without adjustment biases internally
// - supply pin with adjustment is driven out
// - power-on: adjustment on, pin is segment
// - power-on: quarter duty, third bias, all off
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_decoder (
  // Core clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link side, on the link clock.
  input wire logic lk_clk,
  input wire logic lk_byte_valid,
  input wire logic lk_byte_first,
  input wire logic [7:0] lk_byte,
  input wire logic lk_read_req,
  output logic lk_busy,
  output logic lk_rd_valid,
  output logic [7:0] lk_rd_data,
  // Display timing read port.
  input wire logic [lcd_pkg::RAM_AW-1:0] disp_addr,
  output logic [7:0] disp_data,
  // Settings.
  output logic duty_eighth,
  output logic bias_quarter,
  output logic osc_on,
  output logic display_on,
  output logic outputs_at_supply,
  output logic frame_rate_double,
  output logic blink_rate_hi,
  output logic blink_rate_lo,
  output logic shared_pin_select,
  output logic voltage_adjust_enable,
  output logic [3:0] voltage_level_code,
  // Derived controls for the voltage logic.
  output logic follower_enable,
  output logic bias_from_internal,
  output logic last_segment_output_en,
  output logic lcd_supply_pin_oe
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_ARG, ST_SKIP} lcd_state_e;

  lcd_byte_if bi ();

  lcd_state_e state_ff;
  logic req_meta_ff, req_ff, req_prev_ff;
  logic ack_ff, rd_pend_ff;
  logic [7:0] rd_hold_ff, cmd_ff;
  logic [5:0] ptr_ff;
  logic duty_ff, bias_ff, osc_ff, disp_ff, blank_ff, frame_ff;
  logic [1:0] blink_ff;
  logic [7:0] volt_ff;
  logic follow_ff, intbias_ff, seg_ff, pin_oe_ff;
  logic ev, ev_cmd, ev_wr, ev_rd, arg_wr;
  logic ram_we;
  logic [7:0] ram_rq;

  lcd_link_rx u_link (
    .lk_clk(lk_clk),
    .rst_n(rst_n),
    .lk_byte_valid(lk_byte_valid),
    .lk_byte_first(lk_byte_first),
    .lk_byte(lk_byte),
    .lk_read_req(lk_read_req),
    .lk_busy(lk_busy),
    .lk_rd_valid(lk_rd_valid),
    .lk_rd_data(lk_rd_data),
    .bi(bi.link)
  );

  // Request toggle crosses on two flops; the third keeps the last value.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_meta_ff <= 1'b0;
      req_ff <= 1'b0;
      req_prev_ff <= 1'b0;
    end else begin
      req_meta_ff <= bi.req_tgl;
      req_ff <= req_meta_ff;
      req_prev_ff <= req_ff;
    end
  end

  assign ev = (req_ff != req_prev_ff);
  assign ev_cmd = ev && (bi.kind == lcd_pkg::LCD_EV_CMD);
  assign ev_wr = ev && (bi.kind == lcd_pkg::LCD_EV_WR);
  assign ev_rd = ev && (bi.kind == lcd_pkg::LCD_EV_RD);
  assign arg_wr = ev_wr && (state_ff == ST_ARG);
  assign ram_we = ev_wr && (state_ff == ST_DATA);

  // Reads answer one cycle late because the RAM output is registered.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      rd_hold_ff <= 8'h00;
    end else begin
      rd_pend_ff <= ev_rd;
      if (rd_pend_ff) rd_hold_ff <= ram_rq;
      if ((ev && !ev_rd) || rd_pend_ff) ack_ff <= !ack_ff;
    end
  end

  assign bi.ack_tgl = ack_ff;
  assign bi.rd_data = rd_hold_ff;

  // Each setting command takes exactly one argument byte.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cmd_ff <= 8'h00;
    end else if (ev_cmd) begin
      cmd_ff <= bi.data;
      case (bi.data)
        lcd_pkg::CMD_DISPLAY_DATA: state_ff <= ST_ADDR;
        lcd_pkg::CMD_MODE_SET,
        lcd_pkg::CMD_SYSTEM_SET,
        lcd_pkg::CMD_FRAME_FREQ,
        lcd_pkg::CMD_BLINK,
        lcd_pkg::CMD_VOLTAGE_SET: state_ff <= ST_ARG;
        default: state_ff <= ST_SKIP;
      endcase
    end else if (ev_wr) begin
      case (state_ff)
        ST_ADDR: state_ff <= ST_DATA;
        ST_ARG: state_ff <= ST_SKIP;
        default: state_ff <= state_ff;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_ff <= lcd_pkg::ADDR_RST;
    end else if (ev_wr && (state_ff == ST_ADDR)) begin
      ptr_ff <= bi.data[lcd_pkg::ADDR_MSB:0];
    end else if (ram_we || rd_pend_ff) begin
      ptr_ff <= ptr_ff + 6'h01;
    end
  end

  lcd_display_ram u_ram (
    .clk(clk),
    .we(ram_we),
    .wa(ptr_ff[lcd_pkg::RAM_AW-1:0]),
    .wd(bi.data),
    .ra(ptr_ff[lcd_pkg::RAM_AW-1:0]),
    .rq(ram_rq),
    .da(disp_addr),
    .dq(disp_data)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {duty_ff, bias_ff} <= lcd_pkg::MODE_RST;
    end else if (arg_wr && (cmd_ff == lcd_pkg::CMD_MODE_SET)) begin
      duty_ff <= bi.data[lcd_pkg::DUTY_BIT];
      bias_ff <= bi.data[lcd_pkg::BIAS_BIT];
    end
  end

  // Display on needs the oscillator, so bit 1 clear turns both off.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {osc_ff, disp_ff} <= lcd_pkg::SYS_RST;
      blank_ff <= 1'b1;
    end else if (arg_wr && (cmd_ff == lcd_pkg::CMD_SYSTEM_SET)) begin
      osc_ff <= bi.data[lcd_pkg::SYS_OSC_BIT];
      disp_ff <= bi.data[lcd_pkg::SYS_OSC_BIT] && bi.data[lcd_pkg::SYS_DISP_BIT];
      blank_ff <= !(bi.data[lcd_pkg::SYS_OSC_BIT] && bi.data[lcd_pkg::SYS_DISP_BIT]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_ff <= lcd_pkg::FRAME_RST;
    end else if (arg_wr && (cmd_ff == lcd_pkg::CMD_FRAME_FREQ)) begin
      frame_ff <= bi.data[lcd_pkg::FRAME_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blink_ff <= lcd_pkg::BLINK_RST;
    end else if (arg_wr && (cmd_ff == lcd_pkg::CMD_BLINK)) begin
      blink_ff <= bi.data[lcd_pkg::BLINK_HI_BIT:lcd_pkg::BLINK_LO_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      volt_ff <= lcd_pkg::VOLT_RST;
    end else if (arg_wr && (cmd_ff == lcd_pkg::CMD_VOLTAGE_SET)) begin
      volt_ff <= {2'h0, bi.data[lcd_pkg::VSEL_BIT:0]};
    end
  end

  // Derived pin and supply controls lag the setting by one cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      follow_ff <= 1'b0;
      intbias_ff <= 1'b0;
      seg_ff <= 1'b1;
      pin_oe_ff <= 1'b0;
    end else begin
      seg_ff <= volt_ff[lcd_pkg::VSEL_BIT];
      follow_ff <= (volt_ff[lcd_pkg::VLVL_MSB:0] != 4'h0) &&
        !(volt_ff[lcd_pkg::VSEL_BIT] && !volt_ff[lcd_pkg::VADJ_BIT]);
      intbias_ff <= volt_ff[lcd_pkg::VSEL_BIT] && !volt_ff[lcd_pkg::VADJ_BIT];
      pin_oe_ff <= !volt_ff[lcd_pkg::VSEL_BIT] && volt_ff[lcd_pkg::VADJ_BIT];
    end
  end

  assign duty_eighth = duty_ff;
  assign bias_quarter = bias_ff;
  assign osc_on = osc_ff;
  assign display_on = disp_ff;
  assign outputs_at_supply = blank_ff;
  assign frame_rate_double = frame_ff;
  assign blink_rate_hi = blink_ff[1];
  assign blink_rate_lo = blink_ff[0];
  assign shared_pin_select = volt_ff[lcd_pkg::VSEL_BIT];
  assign voltage_adjust_enable = volt_ff[lcd_pkg::VADJ_BIT];
  assign voltage_level_code = volt_ff[lcd_pkg::VLVL_MSB:0];
  assign follower_enable = follow_ff;
  assign bias_from_internal = intbias_ff;
  assign last_segment_output_en = seg_ff;
  assign lcd_supply_pin_oe = pin_oe_ff;

  sequence s_arg(logic [7:0] c);
    arg_wr && (cmd_ff == c);
  endsequence

  property p_addr;
    @(posedge clk) disable iff (!rst_n)
    ev_wr && (state_ff == ST_ADDR) |=> (ptr_ff == $past(bi.data[5:0])) && (state_ff == ST_DATA);
  endproperty
  a_addr: assert property (p_addr) else $error("start address not loaded");

  property p_inc;
    @(posedge clk) disable iff (!rst_n)
    ram_we || rd_pend_ff |=> ptr_ff == $past(ptr_ff) + 6'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer did not advance");

  property p_wr;
    @(posedge clk) disable iff (!rst_n)
    ev_wr && (state_ff == ST_DATA) |-> ##1 (ptr_ff[3:0] == $past(ptr_ff[3:0]) + 4'h1)
      ##2 (u_ram.mem[$past(ptr_ff[3:0], 3)] == $past(bi.data, 3));
  endproperty
  a_wr: assert property (p_wr) else $error("data byte not stored");

  property p_mode;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_MODE_SET) |=> {duty_eighth, bias_quarter} == $past(bi.data[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode byte not applied");

  property p_sys;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_SYSTEM_SET) |=>
      (osc_on == $past(bi.data[1])) && (display_on == ($past(bi.data[1]) && $past(bi.data[0])));
  endproperty
  a_sys: assert property (p_sys) else $error("system byte wrong");

  property p_frame;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_FRAME_FREQ) |=> frame_rate_double == $past(bi.data[0]);
  endproperty
  a_frame: assert property (p_frame) else $error("frame rate wrong");

  property p_blink;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_BLINK) |=> {blink_rate_hi, blink_rate_lo} == $past(bi.data[1:0]);
  endproperty
  a_blink: assert property (p_blink) else $error("blink rate wrong");

  property p_follow;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_VOLTAGE_SET) |-> ##2 (follower_enable ==
      (($past(bi.data[3:0], 2) != 4'h0) && !($past(bi.data[5], 2) && !$past(bi.data[4], 2))));
  endproperty
  a_follow: assert property (p_follow) else $error("follower state wrong");

  property p_skip;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == ST_SKIP) && !ev_cmd |=> $stable(volt_ff) && $stable(blink_ff) && $stable(osc_ff);
  endproperty
  a_skip: assert property (p_skip) else $error("ignored byte changed a setting");

  property p_ack;
    @(posedge clk) disable iff (!rst_n)
    ev |-> ##[1:2] (ack_ff != $past(ack_ff));
  endproperty
  a_ack: assert property (p_ack) else $error("byte event not acknowledged");

  property p_adj;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_VOLTAGE_SET) |=> voltage_adjust_enable == $past(bi.data[4]);
  endproperty
  a_adj: assert property (p_adj) else $error("adjust enable wrong");

  property p_seg;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_VOLTAGE_SET) |-> ##2 (last_segment_output_en == $past(bi.data[5], 2));
  endproperty
  a_seg: assert property (p_seg) else $error("shared pin role wrong");

  property p_intbias;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_VOLTAGE_SET) |-> ##2 (bias_from_internal ==
      ($past(bi.data[5], 2) && !$past(bi.data[4], 2)));
  endproperty
  a_intbias: assert property (p_intbias) else $error("bias source wrong");

  property p_pin_oe;
    @(posedge clk) disable iff (!rst_n)
    s_arg(lcd_pkg::CMD_VOLTAGE_SET) |-> ##2 (lcd_supply_pin_oe ==
      (!$past(bi.data[5], 2) && $past(bi.data[4], 2)));
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("supply pin drive wrong");

  // Checked without a disable so that the reset values themselves are watched.
  property p_por;
    @(posedge clk)
    !rst_n |=> !duty_eighth && !bias_quarter && !osc_on && !display_on && outputs_at_supply &&
      !frame_rate_double && !blink_rate_hi && !blink_rate_lo && shared_pin_select &&
      voltage_adjust_enable && last_segment_output_en && !follower_enable && !lcd_supply_pin_oe;
  endproperty
  a_por: assert property (p_por) else $error("power-on settings wrong");
endmodule : lcd_cmd_decoder
`default_nettype wire

/* verif/lcd_host_model.sv */
// Host model that clocks the link and offers command, argument, data and read requests.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model #(
  parameter int STARTUP_NS = 1000000
) (
  // Link clock made by the host.
  output logic lk_clk,
  // Offers to the device.
  output logic lk_byte_valid,
  output logic lk_byte_first,
  output logic [7:0] lk_byte,
  output logic lk_read_req,
  // Answers from the device.
  input wire logic lk_busy,
  input wire logic lk_rd_valid,
  input wire logic [7:0] lk_rd_data
);
  logic lk_run = 1'b0;
  // Counts handshakes that never completed, so a stuck link fails the run.
  int stalls = 0;
  // The link clock stands low between transfers, as a real bus master leaves it.
  initial begin
    lk_clk = 1'b0;
    lk_byte_valid = 1'b0;
    lk_byte_first = 1'b0;
    lk_byte = 8'h00;
    lk_read_req = 1'b0;
    #5.3;
    forever begin
      #80;
      lk_clk = lk_run ? ~lk_clk : 1'b0;
    end
  end
  task automatic clocks(input int n);
    lk_run = 1'b1;
    repeat (n) @(posedge lk_clk);
    lk_run = 1'b0;
  endtask : clocks
  // The offer is held until an edge with the device idle takes it.
  task automatic offer(input logic rd, input logic first, input logic [7:0] b,
                       output logic [7:0] q);
    int n;
    logic got;
    while ($time < STARTUP_NS) #1000;
    lk_run = 1'b1;
    @(negedge lk_clk);
    lk_read_req = rd;
    lk_byte_valid = !rd;
    lk_byte_first = first;
    lk_byte = b;
    n = 0;
    while (lk_busy && n < 64) begin
      @(negedge lk_clk);
      n++;
    end
    if (n >= 64) stalls++;
    @(negedge lk_clk);
    // Released byte and first lines show the inverse and both request lines drop, so a stale value is never mistaken for a fresh one.
    lk_read_req = 1'b0;
    lk_byte_valid = 1'b0;
    lk_byte_first = !first;
    lk_byte = ~b;
    got = !rd;
    q = 8'h00;
    n = 0;
    while ((lk_busy || !got) && n < 64) begin
      if (lk_rd_valid) begin
        q = lk_rd_data;
        got = 1'b1;
      end
      @(negedge lk_clk);
      n++;
    end
    if (n >= 64) stalls++;
    lk_run = 1'b0;
  endtask : offer
endmodule : lcd_host_model
`default_nettype wire

/* verif/lcd_cmd_decoder_bench.sv */
// Self-checking bench of the LCD command decoder driven by the host model.
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_decoder_bench;
  typedef struct {logic [7:0] cmd; logic [7:0] arg; logic [12:0] exp;} lcd_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lk_clk, lk_byte_valid, lk_byte_first, lk_read_req, lk_busy, lk_rd_valid;
  logic [7:0] lk_byte, lk_rd_data, disp_data, q;
  logic [lcd_pkg::RAM_AW-1:0] disp_addr = 4'h0;
  logic duty_eighth, bias_quarter, osc_on, display_on, outputs_at_supply, frame_rate_double;
  logic blink_rate_hi, blink_rate_lo, shared_pin_select, voltage_adjust_enable;
  logic [3:0] voltage_level_code;
  logic follower_enable, bias_from_internal, last_segment_output_en, lcd_supply_pin_oe;
  int fail_count = 0;
  int samples_checked = 0;
  wire logic [17:0] outs = {duty_eighth, bias_quarter, osc_on, display_on, frame_rate_double,
    blink_rate_hi, blink_rate_lo, shared_pin_select, voltage_adjust_enable, voltage_level_code,
    outputs_at_supply, follower_enable, bias_from_internal, last_segment_output_en,
    lcd_supply_pin_oe};
  lcd_row_s rows[20] = '{
    '{8'h82, 8'hFE, 13'h1030}, '{8'h82, 8'h01, 13'h0830},
    '{8'h84, 8'h02, 13'h0C30}, '{8'h84, 8'hFF, 13'h0E30},
    '{8'h84, 8'h01, 13'h0830}, '{8'h84, 8'h03, 13'h0E30},
    '{8'h86, 8'hFF, 13'h0F30}, '{8'h88, 8'h01, 13'h0F70},
    '{8'h88, 8'h02, 13'h0FB0}, '{8'h88, 8'hFF, 13'h0FF0},
    '{8'h88, 8'h00, 13'h0F30},
    '{8'h8A, 8'h00, 13'h0F00},
    '{8'h8A, 8'h05, 13'h0F05},
    '{8'h8A, 8'h1F, 13'h0F1F}, '{8'h8A, 8'h27, 13'h0F27},
    '{8'h8A, 8'hF8, 13'h0F38}, '{8'h8C, 8'h00, 13'h0F38},
    '{8'h80, 8'hC3, 13'h0F38}, '{8'h84, 8'h00, 13'h0938},
    '{8'h86, 8'h00, 13'h0838}};

  always #4 clk = ~clk;

  lcd_host_model #(.STARTUP_NS(2000)) lcd_host_model_inst (.lk_clk, .lk_byte_valid,
    .lk_byte_first, .lk_byte, .lk_read_req, .lk_busy, .lk_rd_valid, .lk_rd_data);
  lcd_cmd_decoder lcd_cmd_decoder_inst (.clk, .rst_n, .lk_clk, .lk_byte_valid, .lk_byte_first,
    .lk_byte, .lk_read_req, .lk_busy, .lk_rd_valid, .lk_rd_data, .disp_addr, .disp_data,
    .duty_eighth, .bias_quarter, .osc_on, .display_on, .outputs_at_supply, .frame_rate_double,
    .blink_rate_hi, .blink_rate_lo, .shared_pin_select, .voltage_adjust_enable,
    .voltage_level_code, .follower_enable, .bias_from_internal, .last_segment_output_en,
    .lcd_supply_pin_oe);

  // Derived pin controls worked out from the stored setting bits.
  function automatic logic [17:0] with_derived(input logic [12:0] s);
    logic seg_no_adj;
    seg_no_adj = s[5] && !s[4];
    return {s, !s[9], (s[3:0] != 4'h0) && !seg_no_adj, seg_no_adj, s[5], !s[5] && s[4]};
  endfunction : with_derived
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic put(input logic first, input logic [7:0] b);
    lcd_host_model_inst.offer(1'b0, first, b, q);
  endtask : put
  task automatic setting(input logic [7:0] c, input logic [7:0] a);
    put(1'b1, c);
    put(1'b0, a);
    repeat (4) @(negedge clk);
  endtask : setting
  task automatic ram_check(input logic [3:0] a, input logic [7:0] exp);
    @(negedge clk);
    disp_addr = a;
    repeat (2) @(negedge clk);
    check(disp_data, exp);
  endtask : ram_check
  task automatic rd_check(input logic [7:0] exp);
    lcd_host_model_inst.offer(1'b1, 1'b0, 8'h00, q);
    check(q, exp);
  endtask : rd_check
  // Reset is held across link edges too, so the link-side synchroniser sees it.
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    lcd_host_model_inst.clocks(4);
    @(negedge clk);
    rst_n = 1'b1;
    lcd_host_model_inst.clocks(4);
    repeat (2) @(negedge clk);
    check(outs, with_derived(13'h0030));
  endtask : do_reset

  initial begin
    #500000;
    fail_count++;
    complete_run();
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      setting(rows[i].cmd, rows[i].arg);
      check(outs, with_derived(rows[i].exp));
    end
    setting(8'h82, 8'h03);
    put(1'b0, 8'h00);
    repeat (4) @(negedge clk);
    check({duty_eighth, bias_quarter}, 2'h3);
    put(1'b1, 8'h80);
    put(1'b0, 8'hC5);
    put(1'b0, 8'hAA);
    put(1'b0, 8'h55);
    put(1'b0, 8'h3C);
    ram_check(4'h5, 8'hAA);
    ram_check(4'h6, 8'h55);
    ram_check(4'h7, 8'h3C);
    put(1'b1, 8'h80);
    put(1'b0, 8'h3F);
    put(1'b0, 8'h11);
    put(1'b0, 8'h22);
    ram_check(4'hF, 8'h11);
    ram_check(4'h0, 8'h22);
    put(1'b1, 8'h80);
    put(1'b0, 8'h06);
    rd_check(8'h55);
    rd_check(8'h3C);
    check(lcd_host_model_inst.stalls, 0);
    do_reset();
    complete_run();
  end
endmodule : lcd_cmd_decoder_bench
`default_nettype wire
